//--- rtl/lpsr_regs.sv
/*
 * Register bank and interrupt logic of an ambient light and proximity sensor.
 * Assumes an I2C slave engine giving byte write and read strobes, and a front end giving results.
 */
// Overview of operation
// - LED pulse current is the 4-bit drive code times 10 mA, capped at 110 mA.
// - One LED pulse per proximity measurement, with ambient rejection sampled alongside.
// - Status register at zero is read-only: power-up bit2, near bit1, ambient bit0.
// - Power-on reset sets the power-up flag, thresholds revert to defaults.
// - Any set status flag pulls the active-low interrupt line low.
// - On first revision the power-up flag does not drive the interrupt line.
// - Reading the status register clears all flags but one set by an event in the read cycle; with none left the line releases.
// - Ambient or near flag is held clear while its enable bit is zero.
// - Ambient flag sets after persist-exceeding window violations or on overflow.
// - Near flag sets when the reading passes the limit in the selected direction beyond the persist count.
// - Ambient result is 14 bits read-only: overflow plus bits 13:8, then 7:0.
// - Proximity result is one read-only byte at offset 0x16.
// - Ambient upper and lower limits are 14-bit read/write split high then low.
// - Main configuration holds trim select, mode and both interrupt enables, reset 0x24.
// - Transmit configuration holds LED drive code and resets to zero.
// - Mode decode: shutdown, three ambient modes, interleaved, proximity only, two reserved.
// - With enable low the channel skips comparison; with it high events set flags.
// - Trim select zero applies user gain trims; one applies factory gains.
`timescale 1ns/100ps
module lpsr_regs #(
	parameter bit FIRST_REV = 1'b0,
	parameter logic [7:0] FACTORY_GREEN = 8'h80,
	parameter logic [7:0] FACTORY_IR = 8'h80
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic amb_valid_in,
	input wire logic [13:0] amb_data_in,
	input wire logic amb_ovf_in,
	input wire logic near_valid_in,
	input wire logic [7:0] near_data_in,
	input wire logic meas_start_in,
	output logic led_pulse_out,
	output logic reject_sample_out,
	output logic [6:0] led_current_ma_out,
	output logic amb_run_out,
	output logic near_run_out,
	output logic [1:0] amb_source_out,
	output logic [7:0] green_gain_out,
	output logic [7:0] ir_gain_out,
	output logic [3:0] ambient_integration_time_out,
	output logic irq_n_out,
	output logic irq_oe_n_out
);
	logic [2:0] flags_q;
	logic [7:0] main_q;
	logic [7:0] rxcfg_q;
	logic [3:0] led_current_code_q;
	logic [14:0] amb_res_q;
	logic [7:0] prox_res_q;
	logic [13:0] up_q;
	logic [13:0] lo_q;
	logic [3:0] persist_q;
	logic near_below_q;
	logic [7:0] plimit_q;
	logic [7:0] gtrim_q;
	logic [7:0] itrim_q;
	logic amb_event;
	logic near_event;
	logic flags_rd;
	logic irq_active;
	logic [2:0] mode;
	lpsr_cfg_if cfg_if ();
	// ****************************************
	// Elaboration checks
	// ****************************************
	// The current output is seven bits wide, so the top step must stay below 128 mA.
	if (int'(lpsr_pkg::LED_CODE_MAX) * lpsr_pkg::LED_STEP_MA > 127) begin : g_led_range
		$error("led current range exceeds its output");
	end
	// ****************************************
	// Checker link
	// ****************************************
	assign cfg_if.amb_en = main_q[lpsr_pkg::BIT_AMB];
	assign cfg_if.near_en = main_q[lpsr_pkg::BIT_NEAR];
	assign cfg_if.amb_persist = persist_q[1:0];
	assign cfg_if.near_persist = persist_q[3:2];
	assign cfg_if.upper = up_q;
	assign cfg_if.lower = lo_q;
	assign cfg_if.near_limit = plimit_q;
	assign cfg_if.near_below = near_below_q;
	lpsr_persist u_persist (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.cfg(cfg_if),
		.amb_valid_in(amb_valid_in & amb_run_out),
		.amb_data_in(amb_data_in),
		.amb_ovf_in(amb_ovf_in),
		.near_valid_in(near_valid_in & near_run_out),
		.near_data_in(near_data_in),
		.amb_event_out(amb_event),
		.near_event_out(near_event)
	);
	assign flags_rd = reg_rd_in && (reg_addr_in == lpsr_pkg::OFS_FLAGS);
	// ****************************************
	// Status flags
	// ****************************************
	// Set beats the read-clear so an event in the read cycle is kept.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			flags_q <= lpsr_pkg::RST_FLAGS[2:0];
		end else begin
			if (flags_rd) begin
				flags_q <= 3'h0;
			end
			if (!main_q[lpsr_pkg::BIT_AMB]) begin
				flags_q[lpsr_pkg::BIT_AMB] <= 1'b0;
			end else if (amb_event) begin
				flags_q[lpsr_pkg::BIT_AMB] <= 1'b1;
			end
			if (!main_q[lpsr_pkg::BIT_NEAR]) begin
				flags_q[lpsr_pkg::BIT_NEAR] <= 1'b0;
			end else if (near_event) begin
				flags_q[lpsr_pkg::BIT_NEAR] <= 1'b1;
			end
		end
	end
	// ****************************************
	// Interrupt pin
	// ****************************************
	assign irq_active = flags_q[lpsr_pkg::BIT_AMB] || flags_q[lpsr_pkg::BIT_NEAR]
		|| (flags_q[lpsr_pkg::BIT_PWR] && !FIRST_REV);
	// Open drain: output always low, enable low only while pulling.
	assign irq_n_out = 1'b0;
	assign irq_oe_n_out = !irq_active;
	// ****************************************
	// Writable registers
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			main_q <= lpsr_pkg::RST_MAIN;
			rxcfg_q <= lpsr_pkg::RST_ZERO;
			led_current_code_q <= lpsr_pkg::RST_ZERO[3:0];
			up_q <= {lpsr_pkg::RST_ZERO[5:0], lpsr_pkg::RST_ZERO};
			lo_q <= {lpsr_pkg::RST_ZERO[5:0], lpsr_pkg::RST_ZERO};
			persist_q <= lpsr_pkg::RST_ZERO[3:0];
			near_below_q <= 1'b0;
			plimit_q <= lpsr_pkg::RST_ZERO;
			gtrim_q <= lpsr_pkg::RST_TRIM;
			itrim_q <= lpsr_pkg::RST_TRIM;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				lpsr_pkg::OFS_MAIN: main_q <= {2'h0, reg_wdata_in[5:0]};
				lpsr_pkg::OFS_RXCFG: rxcfg_q <= {4'h0, reg_wdata_in[3:0]};
				lpsr_pkg::OFS_TXCFG: led_current_code_q <= reg_wdata_in[3:0];
				lpsr_pkg::OFS_UP_HI: up_q[13:8] <= reg_wdata_in[5:0];
				lpsr_pkg::OFS_UP_LO: up_q[7:0] <= reg_wdata_in;
				lpsr_pkg::OFS_LO_HI: lo_q[13:8] <= reg_wdata_in[5:0];
				lpsr_pkg::OFS_LO_LO: lo_q[7:0] <= reg_wdata_in;
				lpsr_pkg::OFS_PERSIST: persist_q <= reg_wdata_in[3:0];
				lpsr_pkg::OFS_PDIR: near_below_q <= reg_wdata_in[lpsr_pkg::BIT_ABOVE];
				lpsr_pkg::OFS_PLIMIT: plimit_q <= reg_wdata_in;
				lpsr_pkg::OFS_GTRIM: gtrim_q <= reg_wdata_in;
				lpsr_pkg::OFS_ITRIM: itrim_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end
	// ****************************************
	// Result capture
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			amb_res_q <= 15'h0000;
			prox_res_q <= lpsr_pkg::RST_ZERO;
		end else begin
			if (amb_valid_in && amb_run_out) begin
				amb_res_q <= {amb_ovf_in, amb_data_in};
			end
			if (near_valid_in && near_run_out) begin
				prox_res_q <= near_data_in;
			end
		end
	end
	// ****************************************
	// Read mux
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				lpsr_pkg::OFS_FLAGS: reg_rdata_out <= {5'h00, flags_q};
				lpsr_pkg::OFS_MAIN: reg_rdata_out <= main_q;
				lpsr_pkg::OFS_RXCFG: reg_rdata_out <= rxcfg_q;
				lpsr_pkg::OFS_TXCFG: reg_rdata_out <= {4'h0, led_current_code_q};
				lpsr_pkg::OFS_AMB_HI: reg_rdata_out <= {1'b0, amb_res_q[14:8]};
				lpsr_pkg::OFS_AMB_LO: reg_rdata_out <= amb_res_q[7:0];
				lpsr_pkg::OFS_UP_HI: reg_rdata_out <= {2'h0, up_q[13:8]};
				lpsr_pkg::OFS_UP_LO: reg_rdata_out <= up_q[7:0];
				lpsr_pkg::OFS_LO_HI: reg_rdata_out <= {2'h0, lo_q[13:8]};
				lpsr_pkg::OFS_LO_LO: reg_rdata_out <= lo_q[7:0];
				lpsr_pkg::OFS_PERSIST: reg_rdata_out <= {4'h0, persist_q};
				lpsr_pkg::OFS_PDIR: reg_rdata_out <= 8'(near_below_q) << lpsr_pkg::BIT_ABOVE;
				lpsr_pkg::OFS_PLIMIT: reg_rdata_out <= plimit_q;
				lpsr_pkg::OFS_GTRIM: reg_rdata_out <= gtrim_q;
				lpsr_pkg::OFS_ITRIM: reg_rdata_out <= itrim_q;
				lpsr_pkg::OFS_PROX: reg_rdata_out <= prox_res_q;
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end
	// ****************************************
	// Mode, gain and LED control
	// ****************************************
	assign mode = main_q[lpsr_pkg::MODE_LSB +: 3];
	always_comb begin
		amb_run_out = 1'b0;
		near_run_out = 1'b0;
		amb_source_out = 2'h0;
		case (mode)
			lpsr_pkg::LPSR_AMB_DIFF: begin
				amb_run_out = 1'b1;
			end
			lpsr_pkg::LPSR_AMB_GREEN: begin
				amb_run_out = 1'b1;
				amb_source_out = 2'h1;
			end
			lpsr_pkg::LPSR_AMB_IR: begin
				amb_run_out = 1'b1;
				amb_source_out = 2'h2;
			end
			lpsr_pkg::LPSR_INTERLEAVE: begin
				amb_run_out = 1'b1;
				near_run_out = 1'b1;
			end
			lpsr_pkg::LPSR_PROX_ONLY: begin
				near_run_out = 1'b1;
			end
			default: begin
				amb_run_out = 1'b0;
			end
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			green_gain_out <= lpsr_pkg::RST_TRIM;
			ir_gain_out <= lpsr_pkg::RST_TRIM;
			ambient_integration_time_out <= 4'h0;
			led_current_ma_out <= 7'h00;
		end else begin
			green_gain_out <= main_q[lpsr_pkg::BIT_TRIM_SEL] ? FACTORY_GREEN : gtrim_q;
			ir_gain_out <= main_q[lpsr_pkg::BIT_TRIM_SEL] ? FACTORY_IR : itrim_q;
			ambient_integration_time_out <= rxcfg_q[3:0];
			// Codes above the top step saturate so the driver is never asked beyond its range.
			led_current_ma_out <= 7'(((led_current_code_q > lpsr_pkg::LED_CODE_MAX) ? lpsr_pkg::LED_CODE_MAX
				: led_current_code_q) * lpsr_pkg::LED_STEP_MA);
		end
	end
	// A request that lands while a pulse stands is dropped, so each measurement gets one pulse only.
	function automatic logic pulse_req(input logic start, input logic run, input logic busy);
		return start && run && !busy;
	endfunction
	// Single pulse per measurement, rejection sampled in the same cycle.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			led_pulse_out <= 1'b0;
			reject_sample_out <= 1'b0;
		end else begin
			led_pulse_out <= pulse_req(meas_start_in, near_run_out, led_pulse_out);
			reject_sample_out <= pulse_req(meas_start_in, near_run_out, led_pulse_out);
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	a_read_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(flags_rd && !amb_event && !near_event) |=> flags_q == 3'h0) else $error("read did not clear");
	a_set_beats_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(flags_rd && amb_event && main_q[0]) |=> flags_q[0]) else $error("event lost on read");
	a_flag_enable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!main_q[0] |=> !flags_q[0]) else $error("ambient flag while disabled");
	a_near_enable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!main_q[lpsr_pkg::BIT_NEAR] |=> !flags_q[lpsr_pkg::BIT_NEAR]) else $error("near flag while disabled");
	a_irq_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(flags_q[1:0] != 2'h0) |-> !irq_oe_n_out) else $error("irq not pulled");
	a_irq_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(flags_q == 3'h0) |-> irq_oe_n_out) else $error("irq held without flag");
	a_pwr_rev: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(FIRST_REV && flags_q[1:0] == 2'h0) |-> irq_oe_n_out) else $error("power flag drove irq");
	a_reset_flags: assert property (@(posedge clk_in)
		$fell(sys_rst_in) |-> flags_q == 3'h4) else $error("power flag not set");
	a_led_scale: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(led_current_code_q == 4'h3) |=> led_current_ma_out == 7'd30) else $error("led current wrong");
	a_trim_factory: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		main_q[5] |=> green_gain_out == FACTORY_GREEN) else $error("user trim used");
	a_prox_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(mode == 3'h1) |-> !near_run_out) else $error("near runs in ambient mode");
	a_near_runs: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(mode == 3'h5) |-> (near_run_out && !amb_run_out)) else $error("proximity only mode wrong");
	a_pulse_single: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		led_pulse_out |=> !led_pulse_out) else $error("second led pulse");
	a_pulse_reject: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		led_pulse_out == reject_sample_out) else $error("rejection not with pulse");
	c_flag_read: cover property (@(posedge clk_in) flags_rd && flags_q[1]);
	c_amb_set: cover property (@(posedge clk_in) amb_event && main_q[0]);
	c_led: cover property (@(posedge clk_in) led_pulse_out);
	c_near_set: cover property (@(posedge clk_in) near_event && main_q[lpsr_pkg::BIT_NEAR]);
	c_overflow: cover property (@(posedge clk_in) amb_valid_in && amb_ovf_in && amb_run_out);
endmodule

//--- rtl/lpsr_pkg.sv
/*
 * Package of the light and proximity sensor register bank: offsets, fields, reset values, modes.
 * Assumes a single clock domain and a byte-wide register access port from an I2C slave engine.
 */
package lpsr_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_MAIN = 8'h01;
	localparam logic [7:0] OFS_RXCFG = 8'h02;
	localparam logic [7:0] OFS_TXCFG = 8'h03;
	localparam logic [7:0] OFS_AMB_HI = 8'h04;
	localparam logic [7:0] OFS_AMB_LO = 8'h05;
	localparam logic [7:0] OFS_UP_HI = 8'h06;
	localparam logic [7:0] OFS_UP_LO = 8'h07;
	localparam logic [7:0] OFS_LO_HI = 8'h08;
	localparam logic [7:0] OFS_LO_LO = 8'h09;
	localparam logic [7:0] OFS_PERSIST = 8'h0a;
	localparam logic [7:0] OFS_PDIR = 8'h0b;
	localparam logic [7:0] OFS_PLIMIT = 8'h0c;
	localparam logic [7:0] OFS_GTRIM = 8'h0f;
	localparam logic [7:0] OFS_ITRIM = 8'h10;
	localparam logic [7:0] OFS_PROX = 8'h16;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_FLAGS = 8'h04;
	localparam logic [7:0] RST_MAIN = 8'h24;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TRIM = 8'h80;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_PWR = 2;
	localparam int BIT_NEAR = 1;
	localparam int BIT_AMB = 0;
	localparam int BIT_TRIM_SEL = 5;
	localparam int MODE_LSB = 2;
	localparam int BIT_ABOVE = 6;
	localparam int PPST_LSB = 2;
	localparam int LED_STEP_MA = 10;
	localparam int LED_MAX_MA = 110;
	localparam logic [3:0] LED_CODE_MAX = 4'(LED_MAX_MA / LED_STEP_MA);
	// ****************************************
	// Modes
	// ****************************************
	typedef enum logic [2:0] {
		LPSR_SHUTDOWN = 3'h0,
		LPSR_AMB_DIFF = 3'h1,
		LPSR_AMB_GREEN = 3'h2,
		LPSR_AMB_IR = 3'h3,
		LPSR_INTERLEAVE = 3'h4,
		LPSR_PROX_ONLY = 3'h5
	} lpsr_mode_t;
endpackage

//--- rtl/lpsr_cfg_if.sv
/*
 * Interface carrying decoded configuration from the register bank to the persist checker.
 * Assumes both ends share the register bank clock.
 */
`timescale 1ns/100ps
interface lpsr_cfg_if;
	logic amb_en;
	logic near_en;
	logic [1:0] amb_persist;
	logic [1:0] near_persist;
	logic [13:0] upper;
	logic [13:0] lower;
	logic [7:0] near_limit;
	logic near_below;
	modport bank (output amb_en, near_en, amb_persist, near_persist, upper, lower, near_limit, near_below);
	modport chk (input amb_en, near_en, amb_persist, near_persist, upper, lower, near_limit, near_below);
endinterface

//--- rtl/lpsr_persist.sv
/*
 * Threshold and persist checker: turns conversion results into one-cycle flag-set events.
 * Assumes result valid strobes are one cycle wide and come from the front-end sequencer.
 */
`timescale 1ns/100ps
module lpsr_persist (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	lpsr_cfg_if.chk cfg,
	input wire logic amb_valid_in,
	input wire logic [13:0] amb_data_in,
	input wire logic amb_ovf_in,
	input wire logic near_valid_in,
	input wire logic [7:0] near_data_in,
	output logic amb_event_out,
	output logic near_event_out
);
	logic [2:0] amb_cnt_q;
	logic [2:0] near_cnt_q;
	logic amb_out;
	logic near_out;
	// ****************************************
	// Limit checks
	// ****************************************
	assign amb_out = (amb_data_in > cfg.upper) || (amb_data_in < cfg.lower);
	// Direction select lets the near channel fire on falling below the limit instead.
	assign near_out = cfg.near_below ? (near_data_in < cfg.near_limit) : (near_data_in > cfg.near_limit);
	// ****************************************
	// Ambient persist
	// ****************************************
	always_ff @(posedge clk_in) begin
		amb_event_out <= 1'b0;
		if (sys_rst_in || !cfg.amb_en) begin
			amb_cnt_q <= 3'h0;
		end else if (amb_valid_in) begin
			if (amb_ovf_in) begin
				amb_event_out <= 1'b1;
			end
			if (!amb_out) begin
				amb_cnt_q <= 3'h0;
			end else if (amb_cnt_q > {1'b0, cfg.amb_persist}) begin
				amb_event_out <= 1'b1;
			end else begin
				amb_cnt_q <= amb_cnt_q + 3'h1;
				if (amb_cnt_q == {1'b0, cfg.amb_persist}) begin
					amb_event_out <= 1'b1;
				end
			end
		end
	end
	// ****************************************
	// Near persist
	// ****************************************
	always_ff @(posedge clk_in) begin
		near_event_out <= 1'b0;
		if (sys_rst_in || !cfg.near_en) begin
			near_cnt_q <= 3'h0;
		end else if (near_valid_in) begin
			if (!near_out) begin
				near_cnt_q <= 3'h0;
			end else if (near_cnt_q >= {1'b0, cfg.near_persist}) begin
				near_event_out <= 1'b1;
			end else begin
				near_cnt_q <= near_cnt_q + 3'h1;
			end
		end
	end
	a_amb_off_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!cfg.amb_en |=> !amb_event_out) else $error("ambient event while disabled");
	a_near_count_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(near_valid_in && !near_out && cfg.near_en) |=> near_cnt_q == 3'h0) else $error("near count kept");
endmodule

//--- verification/lpsr_host_model.sv
/*
 * Host side model of the shared interrupt line: the pull-up and the level the host sees.
 * Assumes the device only sinks the line through its output enable and never drives it high.
 */
`timescale 1ns/100ps
module lpsr_host_model (
	input wire logic irq_n_in,
	input wire logic irq_oe_n_in,
	output logic irq_line_out
);
	// ****************************************
	// Interrupt line
	// ****************************************
	// The resistor is the only source of a high level, so a released line reads one.
	assign irq_line_out = irq_oe_n_in ? 1'b1 : irq_n_in;
endmodule

//--- verification/light_prox_sensor_regs_irq_tb.sv
/*
 * Self-checking bench of the sensor register bank: registers, flags, interrupt line, decoded outputs.
 * Assumes the byte access strobes of the notes and a host model that supplies the line pull-up.
 */
`timescale 1ns/100ps
module light_prox_sensor_regs_irq_tb;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, amb_valid = 1'b0, amb_ovf = 1'b0, near_valid = 1'b0, meas_start = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, near_data = 8'h00;
	logic [13:0] amb_data = 14'h0000;
	logic [7:0] reg_rdata, g_gain, i_gain;
	logic led_pulse, reject_sample, amb_run, near_run, irq_n, irq_oe_n, irq_line, rev1_oe_n;
	logic [6:0] led_ma;
	logic [1:0] amb_src;
	logic [3:0] int_time;
	int err_count = 0;
	int samples_checked = 0;
	// Factory gains are arbitrary values, distinct from the trim reset value.
	lpsr_regs #(.FIRST_REV(1'b0), .FACTORY_GREEN(8'h5a), .FACTORY_IR(8'h3c)) i_lpsr_regs (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
		.amb_valid_in(amb_valid), .amb_data_in(amb_data), .amb_ovf_in(amb_ovf),
		.near_valid_in(near_valid), .near_data_in(near_data), .meas_start_in(meas_start),
		.led_pulse_out(led_pulse), .reject_sample_out(reject_sample), .led_current_ma_out(led_ma),
		.amb_run_out(amb_run), .near_run_out(near_run), .amb_source_out(amb_src),
		.green_gain_out(g_gain), .ir_gain_out(i_gain), .ambient_integration_time_out(int_time),
		.irq_n_out(irq_n), .irq_oe_n_out(irq_oe_n)
	);
	lpsr_host_model i_lpsr_host_model (.irq_n_in(irq_n), .irq_oe_n_in(irq_oe_n), .irq_line_out(irq_line));
	// A first-revision copy shares every input; only its interrupt enable is watched.
	lpsr_regs #(.FIRST_REV(1'b1), .FACTORY_GREEN(8'h5a), .FACTORY_IR(8'h3c)) i_lpsr_regs_rev1 (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(),
		.amb_valid_in(amb_valid), .amb_data_in(amb_data), .amb_ovf_in(amb_ovf),
		.near_valid_in(near_valid), .near_data_in(near_data), .meas_start_in(meas_start),
		.led_pulse_out(), .reject_sample_out(), .led_current_ma_out(),
		.amb_run_out(), .near_run_out(), .amb_source_out(),
		.green_gain_out(), .ir_gain_out(), .ambient_integration_time_out(),
		.irq_n_out(), .irq_oe_n_out(rev1_oe_n)
	);
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	// Each conversion task returns once the flag set by that result is visible.
	task automatic amb(input logic [13:0] d, input logic o);
		@(posedge clk_in);
		amb_valid <= 1'b1;
		amb_data <= d;
		amb_ovf <= o;
		@(posedge clk_in);
		amb_valid <= 1'b0;
		amb_ovf <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	task automatic near(input logic [7:0] d);
		@(posedge clk_in);
		near_valid <= 1'b1;
		near_data <= d;
		@(posedge clk_in);
		near_valid <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		logic [7:0] a [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
			8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0f, 8'h10, 8'h16};
		logic [7:0] e [17] = '{8'h04, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00};
		chk(8'(irq_line), 8'h00);
		chk(8'(rev1_oe_n), 8'h01);
		chk(g_gain, 8'h5a);
		for (int i = 0; i < 17; i++) rdc(a[i], e[i]);
		chk(8'(irq_line), 8'h01);
		rdc(8'h00, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_rw;
		logic [7:0] a [16] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0f, 8'h10,
			8'h04, 8'h05, 8'h16, 8'h0d, 8'h00};
		logic [7:0] v [16] = '{8'h0b, 8'h07, 8'h2a, 8'h5c, 8'h15, 8'ha3, 8'h0f, 8'h40, 8'hc3, 8'h11, 8'h22,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 16; i++) wr(a[i], i < 11 ? v[i] : 8'hff);
		for (int i = 0; i < 16; i++) rdc(a[i], v[i]);
		chk(8'(int_time), 8'h0b);
		$display("test register access done");
	endtask
	task automatic t_trim;
		wr(8'h01, 8'h04);
		repeat (2) @(posedge clk_in);
		#1 chk(g_gain, 8'h11);
		chk(i_gain, 8'h22);
		wr(8'h01, 8'h24);
		wr(8'h0f, 8'h77);
		repeat (2) @(posedge clk_in);
		#1 chk(g_gain, 8'h5a);
		chk(i_gain, 8'h3c);
		$display("test gain trim done");
	endtask
	task automatic t_led;
		int ma;
		for (int c = 0; c < 16; c++) begin
			wr(8'h03, 8'(c));
			repeat (2) @(posedge clk_in);
			ma = c * 10 > 110 ? 110 : c * 10;
			#1 chk(8'(led_ma), 8'(ma));
		end
		$display("test led current done");
	endtask
	task automatic t_mode;
		logic ea, en;
		for (int m = 0; m < 8; m++) begin
			wr(8'h01, 8'(m << 2));
			@(posedge clk_in);
			ea = m >= 1 && m <= 4;
			en = m == 4 || m == 5;
			#1 chk({6'h00, amb_run, near_run}, {6'h00, ea, en});
			if (ea && m != 4) chk(8'(amb_src), 8'(m - 1));
		end
		$display("test mode decode done");
	endtask
	task automatic t_pulse;
		int cnt;
		for (int k = 0; k < 2; k++) begin
			wr(8'h01, k == 0 ? 8'h14 : 8'h04);
			cnt = 0;
			@(posedge clk_in);
			meas_start <= 1'b1;
			@(posedge clk_in);
			meas_start <= 1'b0;
			for (int c = 0; c < 4; c++) begin
				#1;
				if (led_pulse === 1'b1) begin
					cnt++;
					chk(8'(reject_sample), 8'h01);
				end
				@(posedge clk_in);
			end
			chk(8'(cnt), k == 0 ? 8'h01 : 8'h00);
		end
		$display("test led pulse done");
	endtask
	task automatic t_amb;
		logic [7:0] d;
		wr(8'h06, 8'h01);
		wr(8'h07, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h10);
		wr(8'h0a, 8'h02);
		wr(8'h01, 8'h25);
		rd(8'h00, d);
		amb(14'h0200, 1'b0);
		amb(14'h0200, 1'b0);
		amb(14'h0050, 1'b0);
		amb(14'h0200, 1'b0);
		amb(14'h0200, 1'b0);
		rdc(8'h00, 8'h00);
		amb(14'h0200, 1'b0);
		chk(8'(irq_line), 8'h00);
		chk(8'(rev1_oe_n), 8'h00);
		rdc(8'h00, 8'h01);
		chk(8'(irq_line), 8'h01);
		amb(14'h0055, 1'b1);
		rdc(8'h04, 8'h40);
		rdc(8'h05, 8'h55);
		wr(8'h01, 8'h24);
		rdc(8'h00, 8'h00);
		for (int i = 0; i < 4; i++) amb(14'h0200, 1'b0);
		rdc(8'h00, 8'h00);
		chk(8'(irq_line), 8'h01);
		wr(8'h01, 8'h25);
		@(posedge clk_in);
		amb_valid <= 1'b1;
		amb_data <= 14'h0055;
		amb_ovf <= 1'b1;
		@(posedge clk_in);
		amb_valid <= 1'b0;
		amb_ovf <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= 8'h00;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		rdc(8'h00, 8'h01);
		wr(8'h0a, 8'h00);
		amb(14'h0005, 1'b0);
		rdc(8'h00, 8'h01);
		$display("test ambient flag done");
	endtask
	task automatic t_near;
		logic [7:0] d;
		wr(8'h0b, 8'h00);
		wr(8'h0c, 8'h40);
		wr(8'h0a, 8'h04);
		wr(8'h01, 8'h12);
		rd(8'h00, d);
		near(8'h80);
		near(8'h10);
		near(8'h80);
		rdc(8'h00, 8'h00);
		near(8'h80);
		chk(8'(irq_line), 8'h00);
		rdc(8'h00, 8'h02);
		rdc(8'h16, 8'h80);
		wr(8'h0a, 8'h00);
		near(8'h40);
		rdc(8'h00, 8'h00);
		near(8'h41);
		rdc(8'h00, 8'h02);
		wr(8'h0b, 8'h40);
		near(8'h50);
		rdc(8'h00, 8'h00);
		near(8'h3f);
		rdc(8'h00, 8'h02);
		$display("test proximity flag done");
	endtask
	task automatic t_rereset;
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		#1 chk(8'(irq_line), 8'h00);
		chk(8'(rev1_oe_n), 8'h01);
		rdc(8'h06, 8'h00);
		rdc(8'h09, 8'h00);
		rdc(8'h0c, 8'h00);
		rdc(8'h0f, 8'h80);
		rdc(8'h00, 8'h04);
		$display("test second reset done");
	endtask
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		t_reset();
		t_rw();
		t_trim();
		t_led();
		t_mode();
		t_pulse();
		t_amb();
		t_near();
		t_rereset();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		$display("mismatch at %0t: run did not complete", $time);
		tally_and_finish();
	end
endmodule
